// ==== rx_pkg.sv ====
/*
  Constants, types and register map of the asynchronous serial receiver.
  Assumes one 100 MHz clock and a plain strobe register port with 8-bit data.
*/
package rx_pkg;
  localparam int unsigned AW = 4;
  localparam int unsigned DW = 8;

  // Register offsets
  localparam logic [3:0] ADR_BAUD_CTRL = 4'h0;
  localparam logic [3:0] ADR_RX_DATA   = 4'h1;
  localparam logic [3:0] ADR_RX_STAT   = 4'h2;
  localparam logic [3:0] ADR_DIV_LO    = 4'h3;
  localparam logic [3:0] ADR_DIV_HI    = 4'h4;
  localparam logic [3:0] ADR_TX_STAT   = 4'h5;
  localparam logic [3:0] ADR_IRQ_STAT  = 4'h6;
  localparam logic [3:0] ADR_IRQ_EN    = 4'h7;
  localparam logic [3:0] ADR_IRQ_CLR   = 4'h8;

  // Baud control fields
  localparam int unsigned BC_OVF  = 7;
  localparam int unsigned BC_IDLE = 6;
  localparam int unsigned BC_POL  = 5;
  localparam int unsigned BC_CKP  = 4;
  localparam int unsigned BC_WIDE = 3;
  localparam logic [7:0]  BC_WMASK = 8'h3B;

  // Receive status and control fields
  localparam int unsigned RS_PORT_EN = 7;
  localparam int unsigned RS_NINE    = 6;
  localparam int unsigned RS_CONT_EN = 4;
  localparam int unsigned RS_FRAME   = 2;
  localparam int unsigned RS_OVERRUN = 1;
  localparam int unsigned RS_NINTH   = 0;
  localparam logic [7:0]  RS_WMASK = 8'hF8;

  // Transmit status and control fields
  localparam int unsigned TS_SYNC = 4;
  localparam int unsigned TS_TRMT = 1;
  localparam logic [7:0]  TS_WMASK = 8'hFD;

  // Interrupt status bits
  localparam int unsigned IRQ_RXC  = 0;
  localparam int unsigned IRQ_OVR  = 1;
  localparam int unsigned IRQ_FRAME = 2;

  // Reset values
  localparam logic [7:0] RST_BAUD = 8'h00;
  localparam logic [7:0] RST_RS   = 8'h00;
  localparam logic [7:0] RST_TS   = 8'h00;
  localparam logic [7:0] RST_DIV  = 8'h00;

  // Oversampling timing in ticks of the 16x enable
  localparam logic [3:0] TICK_HALF = 4'h7;
  localparam logic [3:0] TICK_S0   = 4'hD;
  localparam logic [3:0] TICK_S1   = 4'hE;
  localparam logic [3:0] TICK_LAST = 4'hF;
  localparam logic [3:0] LAST_BIT8 = 4'h7;
  localparam logic [3:0] LAST_BIT9 = 4'h8;

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_state_t;
endpackage : rx_pkg

// ==== baud_if.sv ====
/*
  Carrier between the receiver and its oversampling tick divider.
  Assumes both ends share I_CLK.
*/
`timescale 1ns/1ps
interface baud_if;
  logic [15:0] divisor;
  logic        tick;
  modport gen  (input divisor, output tick);
  modport user (output divisor, input tick);
endinterface : baud_if

// ==== baud_tick.sv ====
/*
  Divider giving a one-cycle 16x-baud enable every divisor+1 clocks.
  Assumes the divisor is static while receiving.
*/
`timescale 1ns/1ps
module baud_tick
(
  input  wire logic I_CLK,
  input  wire logic I_RESET,
  baud_if.gen       b
);
  typedef struct packed {
    logic [15:0] cnt;
    logic        tick;
  } tick_state_t;

  tick_state_t q_q;
  tick_state_t q_d;

  always_comb
  begin
    q_d = q_q;
    if (q_q.cnt == 16'h0000)
    begin
      q_d.cnt  = b.divisor;
      q_d.tick = 1'b1;
    end
    else
    begin
      q_d.cnt  = q_q.cnt - 16'h0001;
      q_d.tick = 1'b0;
    end
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
      q_q <= '0;
    else
      q_q <= q_d;
  end

  assign b.tick = q_q.tick;
endmodule : baud_tick

// ==== async_serial_receiver.sv ====
/*
  Asynchronous serial receiver: 16x oversampled bit recovery, two-entry
  receive queue, overrun stall, polarity control, registers and interrupt.
  Assumes a register master that strobes one cycle at a time and a serial
  input already synchronous to I_CLK.
*/
// Strobed register access and the register offsets were decided locally.
`timescale 1ns/1ps
module async_serial_receiver
  import rx_pkg::*;
(
  input  wire logic              I_CLK,
  input  wire logic              I_RESET,
  input  wire logic [rx_pkg::AW-1:0] I_ADDR,
  input  wire logic [rx_pkg::DW-1:0] I_WDATA,
  input  wire logic              I_WR,
  input  wire logic              I_RD,
  input  wire logic              I_RX,
  output logic [rx_pkg::DW-1:0]  O_RDATA,
  output logic                   O_IRQ,
  output logic                   O_RX_INT_FLAG
);
  import rx_pkg::*;

  typedef struct packed {
    logic [7:0]      baud;
    logic [7:0]      rsc;
    logic [7:0]      tsc;
    logic [7:0]      dlo;
    logic [7:0]      dhi;
    logic [2:0]      ist;
    logic [2:0]      ien;
    logic            ovr_err;
    rx_state_t       st;
    logic [3:0]      tcnt;
    logic [3:0]      bcnt;
    logic [8:0]      sh;
    logic [1:0]      smp;
    logic            prev;
    logic [1:0][9:0] fq;
    logic [1:0]      cnt;
    logic            head;
    logic [7:0]      rdata;
  } rx_core_t;

  rx_core_t q_q;
  rx_core_t q_d;

  baud_if bif ();

  logic       tick;
  logic       line;
  logic       rx_en;
  logic       vote;
  logic       wr_baud;
  logic       pop;
  logic       push;
  logic       done;
  logic [9:0] head_ent;
  logic [3:0] last_bit;

  //////////////////////////////////////////////////////////////////////////
  // Oversampling tick
  //////////////////////////////////////////////////////////////////////////
  assign bif.divisor = q_q.baud[BC_WIDE] ? {q_q.dhi, q_q.dlo} : {8'h00, q_q.dlo};

  baud_tick u_tick
  (
    .I_CLK   (I_CLK),
    .I_RESET (I_RESET),
    .b       (bif.gen)
  );

  assign tick = bif.tick;

  //////////////////////////////////////////////////////////////////////////
  // Line conditioning and shared terms
  //////////////////////////////////////////////////////////////////////////
  // Inversion applies only outside synchronous mode
  assign line = I_RX ^ (q_q.baud[BC_POL] & ~q_q.tsc[TS_SYNC]);
  assign rx_en = q_q.rsc[RS_CONT_EN] & q_q.rsc[RS_PORT_EN] & ~q_q.tsc[TS_SYNC];
  assign vote = (q_q.smp[0] & q_q.smp[1]) | (q_q.smp[0] & line)
              | (q_q.smp[1] & line);
  assign last_bit = q_q.rsc[RS_NINE] ? LAST_BIT9 : LAST_BIT8;
  assign head_ent = (q_q.cnt != 2'd0) ? q_q.fq[q_q.head] : 10'h000;
  assign pop = I_RD && (I_ADDR == ADR_RX_DATA) && (q_q.cnt != 2'd0);
  assign done = (q_q.st == RX_STOP) && tick && (q_q.tcnt == TICK_LAST) && rx_en;
  assign push = done && ((q_q.cnt != 2'd2) || pop);
  assign wr_baud = I_WR && (I_ADDR == ADR_BAUD_CTRL);

  //////////////////////////////////////////////////////////////////////////
  // Next state
  //////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    logic [2:0] ev;
    logic       slot;
    ev   = 3'b000;
    slot = q_q.head ^ q_q.cnt[0];
    q_d  = q_q;
    q_d.prev  = line;
    q_d.rdata = 8'h00;

    // Register writes
    if (wr_baud)
      q_d.baud = I_WDATA & BC_WMASK;
    else if (I_WR && (I_ADDR == ADR_RX_STAT))
    begin
      q_d.rsc = I_WDATA & RS_WMASK;
      if (!I_WDATA[RS_CONT_EN])
        q_d.ovr_err = 1'b0;
    end
    else if (I_WR && (I_ADDR == ADR_DIV_LO))
      q_d.dlo = I_WDATA;
    else if (I_WR && (I_ADDR == ADR_DIV_HI))
      q_d.dhi = I_WDATA;
    else if (I_WR && (I_ADDR == ADR_TX_STAT))
      q_d.tsc = I_WDATA & TS_WMASK;
    else if (I_WR && (I_ADDR == ADR_IRQ_EN))
      q_d.ien = I_WDATA[2:0];
    else if (I_WR && (I_ADDR == ADR_IRQ_CLR))
      q_d.ist = q_q.ist & ~I_WDATA[2:0];

    // Register reads; queue head visible through the data and receive status registers, popped only by the data register
    if (I_RD)
    begin
      if (I_ADDR == ADR_BAUD_CTRL)
        q_d.rdata = q_q.baud | {1'b0, (q_q.st == RX_IDLE), 6'h00};
      else if (I_ADDR == ADR_RX_DATA)
        q_d.rdata = head_ent[7:0];
      else if (I_ADDR == ADR_RX_STAT)
        q_d.rdata = {q_q.rsc[7:3], head_ent[9], q_q.ovr_err, head_ent[8]};
      else if (I_ADDR == ADR_DIV_LO)
        q_d.rdata = q_q.dlo;
      else if (I_ADDR == ADR_DIV_HI)
        q_d.rdata = q_q.dhi;
      else if (I_ADDR == ADR_TX_STAT)
        q_d.rdata = q_q.tsc | (8'h01 << TS_TRMT);
      else if (I_ADDR == ADR_IRQ_STAT)
        q_d.rdata = {5'h00, q_q.ist};
      else if (I_ADDR == ADR_IRQ_EN)
        q_d.rdata = {5'h00, q_q.ien};
      else
        q_d.rdata = 8'h00;
    end

    // Bit recovery
    case (q_q.st)
      RX_IDLE:
      begin
        if (rx_en && !q_q.ovr_err && q_q.prev && !line)
        begin
          q_d.st   = RX_START;
          q_d.tcnt = 4'h0;
        end
      end
      RX_START:
      begin
        if (tick)
        begin
          q_d.tcnt = q_q.tcnt + 4'h1;
          if (q_q.tcnt == TICK_HALF)
          begin
            q_d.tcnt = 4'h0;
            q_d.bcnt = 4'h0;
            q_d.st   = line ? RX_IDLE : RX_DATA;
          end
        end
      end
      RX_DATA:
      begin
        if (tick)
        begin
          q_d.tcnt = q_q.tcnt + 4'h1;
          if (q_q.tcnt == TICK_S0)
            q_d.smp[0] = line;
          if (q_q.tcnt == TICK_S1)
            q_d.smp[1] = line;
          if (q_q.tcnt == TICK_LAST)
          begin
            q_d.sh   = {vote, q_q.sh[8:1]};
            q_d.bcnt = q_q.bcnt + 4'h1;
            if (q_q.bcnt == last_bit)
              q_d.st = RX_STOP;
          end
        end
      end
      RX_STOP:
      begin
        if (tick)
        begin
          q_d.tcnt = q_q.tcnt + 4'h1;
          if (q_q.tcnt == TICK_S0)
            q_d.smp[0] = line;
          if (q_q.tcnt == TICK_S1)
            q_d.smp[1] = line;
          if (q_q.tcnt == TICK_LAST)
            q_d.st = RX_IDLE;
        end
      end
      default:
        q_d.st = RX_IDLE;
    endcase

    if (!rx_en)
      q_d.st = RX_IDLE;

    // Queue: pop head, push behind the last unread entry
    if (pop)
      q_d.head = ~q_q.head;
    if (push)
    begin
      q_d.fq[slot] = {~vote, q_q.rsc[RS_NINE] ? q_q.sh : {1'b0, q_q.sh[8:1]}};
      ev[IRQ_RXC]   = 1'b1;
      ev[IRQ_FRAME] = ~vote;
    end
    else if (done)
    begin
      q_d.ovr_err = 1'b1;
      ev[IRQ_OVR] = 1'b1;
    end
    q_d.cnt = q_q.cnt + {1'b0, push} - {1'b0, pop};

    // Hardware set wins over a software clear in the same cycle
    q_d.ist = q_d.ist | ev;
  end

  always_ff @(posedge I_CLK)
  begin
    if (I_RESET)
    begin
      q_q      <= '0;
      q_q.baud <= RST_BAUD;
      q_q.rsc  <= RST_RS;
      q_q.tsc  <= RST_TS;
      q_q.dlo  <= RST_DIV;
      q_q.dhi  <= RST_DIV;
      q_q.prev <= 1'b1;
      q_q.st   <= RX_IDLE;
    end
    else
      q_q <= q_d;
  end

  //////////////////////////////////////////////////////////////////////////
  // Outputs
  //////////////////////////////////////////////////////////////////////////
  assign O_RDATA       = q_q.rdata;
  assign O_RX_INT_FLAG = (q_q.cnt != 2'd0);
  assign O_IRQ         = |(q_q.ist & q_q.ien);

  //////////////////////////////////////////////////////////////////////////
  // Checks
  //////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RESET);

  a_half_bit_abort: assert property (
    (q_q.st == RX_START) && tick && (q_q.tcnt == TICK_HALF) && line && rx_en
    |=> (q_q.st == RX_IDLE) && (q_q.cnt == $past(q_q.cnt) - {1'b0, $past(pop)}))
    else $error("false start not dropped");

  a_start_confirm: assert property (
    (q_q.st == RX_START) && tick && (q_q.tcnt == TICK_HALF) && !line && rx_en
    |=> (q_q.st == RX_DATA) && (q_q.bcnt == 4'h0))
    else $error("confirmed start did not enter data");

  a_bit_hold: assert property (
    (q_q.st == RX_DATA) && !tick |=> $stable(q_q.sh) && $stable(q_q.bcnt))
    else $error("shifter moved without a bit tick");

  a_queue_depth: assert property (
    q_q.cnt <= 2'd2)
    else $error("queue count above two");

  a_enable_gate: assert property (
    !rx_en |=> (q_q.st == RX_IDLE))
    else $error("receiver active while disabled");

  a_overrun_stall: assert property (
    q_q.ovr_err && (q_q.st == RX_IDLE) |=> (q_q.st == RX_IDLE))
    else $error("reception resumed during overrun");

  a_push_flag: assert property (
    push |=> O_RX_INT_FLAG && q_q.ist[IRQ_RXC])
    else $error("completed character did not raise flag");

  a_pop_data: assert property (
    pop |=> (O_RDATA == $past(head_ent[7:0])) && (q_q.head != $past(q_q.head)))
    else $error("read did not return and remove oldest entry");

  a_flag_clear: assert property (
    pop && (q_q.cnt == 2'd1) && !push |=> !O_RX_INT_FLAG)
    else $error("flag stayed after queue emptied");

  a_overrun_set: assert property (
    done && (q_q.cnt == 2'd2) && !pop |=> q_q.ovr_err && (q_q.cnt == 2'd2))
    else $error("overrun not flagged on full queue");

  a_stop_frame: assert property (
    push |=> (q_q.fq[$past(q_q.head ^ q_q.cnt[0])][9] == !$past(vote))
             && (q_q.ist[IRQ_FRAME] || $past(vote)))
    else $error("framing error lost");

  a_bit_count: assert property (
    (q_q.st == RX_DATA) |-> (q_q.bcnt <= LAST_BIT9))
    else $error("data bit count beyond character width");

  a_last_bit: assert property (
    (q_q.st == RX_DATA) && tick && (q_q.tcnt == TICK_LAST) && (q_q.bcnt == last_bit) && rx_en
    |=> (q_q.st == RX_STOP))
    else $error("last data bit did not lead to stop");

  a_stop_end: assert property (
    (q_q.st == RX_STOP) && tick && (q_q.tcnt == TICK_LAST) && rx_en |=> (q_q.st == RX_IDLE))
    else $error("stop bit did not end the character");

  a_empty_read: assert property (
    I_RD && (I_ADDR == ADR_RX_DATA) && (q_q.cnt == 2'd0)
    |=> (O_RDATA == 8'h00) && $stable(q_q.head))
    else $error("read of empty queue moved or returned data");

  a_read_idle: assert property (
    !I_RD |=> (O_RDATA == 8'h00))
    else $error("read data present without a read");

  a_baud_write: assert property (
    wr_baud |=> (q_q.baud == ($past(I_WDATA) & BC_WMASK)))
    else $error("baud control write not masked");

  a_idle_read: assert property (
    I_RD && (I_ADDR == ADR_BAUD_CTRL)
    |=> (O_RDATA[BC_IDLE] == ($past(q_q.st) == RX_IDLE)) && !O_RDATA[BC_OVF])
    else $error("idle or overflow bit misread");

  a_overrun_clear: assert property (
    I_WR && (I_ADDR == ADR_RX_STAT) && !I_WDATA[RS_CONT_EN] && !done |=> !q_q.ovr_err)
    else $error("overrun not cleared by software");

  c_false_start: cover property (
    (q_q.st == RX_START) ##1 (q_q.st == RX_IDLE));
  c_char_rx: cover property (push);
  c_queue_full: cover property (q_q.cnt == 2'd2);
  c_overrun: cover property ($rose(q_q.ovr_err));
  c_nine_bit: cover property (push && q_q.rsc[RS_NINE]);
endmodule : async_serial_receiver

// ==== serial_tx_model.sv ====
/*
  Behavioural model of the remote asynchronous transmitter driving the serial input.
  Assumes the receiver clock; one bit lasts BIT_CLKS clocks; the line idles at mark.
*/
`timescale 1ns/1ps
module serial_tx_model
#(
  parameter int unsigned BIT_CLKS = 32
)
(
  input  wire logic i_clk,
  output logic      o_line
);
  logic inv_q;

  initial
  begin
    inv_q  = 1'b0;
    o_line = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Holds one logical level for n clocks, inverted on a low-true link
  task automatic hold(input logic lvl, input int unsigned n);
    @(posedge i_clk);
    o_line <= lvl ^ inv_q;
    repeat (n - 1) @(posedge i_clk);
  endtask : hold

  // Switches link polarity and parks the line at the new idle level
  task automatic set_inv(input logic v);
    @(posedge i_clk);
    inv_q  <= v;
    o_line <= ~v;
  endtask : set_inv

  // One frame: start, nb data bits LSB first, stop, then two idle bits
  task automatic send(input logic [8:0] d, input int unsigned nb, input logic stop);
    hold(1'b0, BIT_CLKS);
    for (int i = 0; i < nb; i++)
      hold(d[i], BIT_CLKS);
    hold(stop, BIT_CLKS);
    hold(1'b1, 2 * BIT_CLKS);
  endtask : send
endmodule : serial_tx_model

// ==== tb.sv ====
/*
  Self-checking testbench of the asynchronous serial receiver.
  Assumes divisor 1 (32 clocks a bit) and the register map of rx_pkg.
*/
`timescale 1ns/1ps
`define CHK(nm, e, g) \
  begin \
    n_checks++; \
    if ((g) !== (e)) \
    begin \
      errors++; \
      $display("mismatch %s exp %h got %h", nm, e, g); \
    end \
  end
module tb;
  import rx_pkg::*;
  localparam int unsigned BIT_CLKS = 32;
  logic          clk;
  logic          rst;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic          wr_s;
  logic          rd_s;
  wire           rx_line;
  logic [DW-1:0] rdata;
  logic          irq;
  logic          rflag;
  int            errors;
  int            n_checks;
  int            seed;
  logic [8:0]    dq [3];
  logic [8:0]    d9;
  logic          nine;
  logic          fe;
  logic [7:0]    ctl;

  async_serial_receiver uut
  (
    .I_CLK         (clk),
    .I_RESET       (rst),
    .I_ADDR        (addr),
    .I_WDATA       (wdata),
    .I_WR          (wr_s),
    .I_RD          (rd_s),
    .I_RX          (rx_line),
    .O_RDATA       (rdata),
    .O_IRQ         (irq),
    .O_RX_INT_FLAG (rflag)
  );

  serial_tx_model #(.BIT_CLKS(BIT_CLKS)) tx
  (
    .i_clk  (clk),
    .o_line (rx_line)
  );

  always #5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clk);
    wr_s  <= 1'b0;
    #1;
  endtask : wr

  task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clk);
    rd_s <= 1'b0;
    #1;
    `CHK(nm, e, rdata)
  endtask : rchk

  // Expected receive status: control bits kept, overrun flag, frame and ninth-bit flags of the head entry
  function automatic logic [7:0] rs_exp(input logic [7:0] c, input logic f, input logic o,
                                        input logic b8);
    rs_exp          = c & RS_WMASK;
    rs_exp[RS_FRAME]   = f;
    rs_exp[RS_OVERRUN] = o;
    rs_exp[RS_NINTH]   = b8;
  endfunction : rs_exp

  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : conclude

  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clk      = 1'b0;
    rst      = 1'b1;
    addr     = '0;
    wdata    = '0;
    wr_s     = 1'b0;
    rd_s     = 1'b0;
    errors   = 0;
    n_checks = 0;
    seed     = 21586;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk("baud rst", ADR_BAUD_CTRL, 8'h40);
    rchk("rs rst", ADR_RX_STAT, RST_RS);
    rchk("ts rst", ADR_TX_STAT, 8'h02);
    rchk("unmapped", 4'h9, 8'h00);
    wr(ADR_DIV_LO, 8'h01);
    rchk("div lo", ADR_DIV_LO, 8'h01);
    wr(ADR_BAUD_CTRL, 8'hFF);
    rchk("baud bits", ADR_BAUD_CTRL, 8'h7B);
    wr(ADR_BAUD_CTRL, 8'h00);
    wr(ADR_RX_DATA, 8'h5A);
    `CHK("no direct fill", 1'b0, rflag)
    // Port enabled but continuous receive off, then synchronous mode selected
    wr(ADR_RX_STAT, 8'h80);
    tx.send(9'h0A5, 8, 1'b1);
    `CHK("off cont", 1'b0, rflag)
    wr(ADR_TX_STAT, 8'h10);
    wr(ADR_RX_STAT, 8'h90);
    tx.send(9'h03C, 8, 1'b1);
    `CHK("off sync", 1'b0, rflag)
    wr(ADR_TX_STAT, 8'h00);
    wr(ADR_IRQ_EN, 8'h07);
    // Three frames unread: two fill the queue, the third overruns
    for (int k = 0; k < 3; k++)
    begin
      dq[k] = 9'($random(seed));
      tx.send(dq[k], 8, 1'b1);
      `CHK("flag set", 1'b1, rflag)
      `CHK("irq set", 1'b1, irq)
    end
    rchk("overrun", ADR_RX_STAT, rs_exp(8'h90, 1'b0, 1'b1, 1'b0));
    rchk("oldest", ADR_RX_DATA, dq[0][7:0]);
    `CHK("flag held", 1'b1, rflag)
    rchk("second", ADR_RX_DATA, dq[1][7:0]);
    `CHK("flag clear", 1'b0, rflag)
    tx.send(9'h155, 8, 1'b1);
    `CHK("stalled", 1'b0, rflag)
    wr(ADR_RX_STAT, 8'h80);
    wr(ADR_RX_STAT, 8'h90);
    rchk("ovr clear", ADR_RX_STAT, rs_exp(8'h90, 1'b0, 1'b0, 1'b0));
    rchk("irq stat", ADR_IRQ_STAT, 8'h03);
    wr(ADR_IRQ_CLR, 8'h07);
    `CHK("irq clr", 1'b0, irq)
    // Random widths and stop levels; first two frames forced corners
    for (int n = 0; n < 6; n++)
    begin
      nine = (n < 2) ? n[0] : 1'($random(seed));
      fe   = (n == 1) ? 1'b1 : ($random(seed) % 4 == 0);
      d9   = 9'($random(seed));
      ctl  = nine ? 8'hD0 : 8'h90;
      wr(ADR_RX_STAT, ctl);
      tx.send(d9, nine ? 9 : 8, ~fe);
      rchk("status", ADR_RX_STAT, rs_exp(ctl, fe, 1'b0, nine & d9[8]));
      rchk("data", ADR_RX_DATA, d9[7:0]);
    end
    rchk("irq framing_error_flag", ADR_IRQ_STAT, 8'h05);
    wr(ADR_IRQ_EN, 8'h00);
    `CHK("irq masked", 1'b0, irq)
    wr(ADR_IRQ_EN, 8'h07);
    `CHK("irq unmasked", 1'b1, irq)
    wr(ADR_IRQ_CLR, 8'h07);
    // Short low pulse shorter than half a bit must be dropped
    wr(ADR_RX_STAT, 8'h90);
    tx.hold(1'b0, BIT_CLKS / 4);
    tx.hold(1'b1, 2 * BIT_CLKS);
    `CHK("glitch", 1'b0, rflag)
    rchk("glitch framing_error_flag", ADR_IRQ_STAT, 8'h00);
    tx.send(9'h0C3, 8, 1'b1);
    rchk("after glitch", ADR_RX_DATA, 8'hC3);
    // High divisor byte must be ignored while the narrow divisor is selected
    wr(ADR_DIV_HI, 8'hFF);
    rchk("div hi", ADR_DIV_HI, 8'hFF);
    // Low-true link
    wr(ADR_RX_STAT, 8'h80);
    tx.set_inv(1'b1);
    wr(ADR_BAUD_CTRL, 8'h20);
    wr(ADR_RX_STAT, 8'h90);
    d9 = 9'($random(seed));
    tx.send(d9, 8, 1'b1);
    rchk("inverted", ADR_RX_DATA, d9[7:0]);
    `CHK("inv empty", 1'b0, rflag)
    // Wide divisor selected at the same rate
    wr(ADR_DIV_HI, 8'h00);
    wr(ADR_BAUD_CTRL, 8'h28);
    d9 = 9'($random(seed));
    tx.send(d9, 8, 1'b1);
    rchk("wide", ADR_RX_DATA, d9[7:0]);
    conclude();
  end
endmodule : tb
